// *** core/tlpiu_pkg.sv ***
// shared constants and types of the two-level priority interrupt unit
package tlpiu_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [1:0] ADDR_MAIN_CONTROL  = 2'h0; // interrupt_main_control
  localparam logic [1:0] ADDR_RESET_CONTROL = 2'h1; // reset_control_register
  localparam logic [1:0] ADDR_PRIORITY      = 2'h2; // source priority bits
  localparam logic [1:0] ADDR_PORT_B        = 2'h3; // port_b_pins read

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_GLOBAL_HIGH = 7; // global / high-level enable
  localparam int BIT_GLOBAL_LOW  = 6; // peripheral / low-level enable
  localparam int BIT_EN_TIMER    = 5;
  localparam int BIT_EN_PIN0     = 4;
  localparam int BIT_EN_PORT     = 3;
  localparam int BIT_FLAG_TIMER  = 2;
  localparam int BIT_FLAG_PIN0   = 1;
  localparam int BIT_FLAG_PORT   = 0;
  localparam int BIT_PRIO_MODE   = 7; // priority_mode_enable
  localparam int BIT_PRI_TIMER   = 2;
  localparam int BIT_PRI_PORT    = 0;

  // ----------------------------------------------------------------
  // reset values and vectors
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_MAIN_CONTROL = 8'h00;
  localparam logic        RST_PRIO_MODE    = 1'b0;
  localparam logic [1:0]  RST_PRIORITY     = 2'h3;
  localparam logic [15:0] VEC_HIGH         = 16'h0008;
  localparam logic [15:0] VEC_LOW          = 16'h0018;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TLPIU_IDLE = 2'b00,
    TLPIU_PUSH = 2'b01,
    TLPIU_LOAD = 2'b10
  } tlpiu_fsm_t;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tlpiu_bus_t;

  typedef struct packed {
    logic [7:0]       ctrl;       // interrupt_main_control
    logic             prio_mode;  // priority_mode_enable
    logic [1:0]       prio;       // [1] timer, [0] port change
    logic [2:0]       pin_sync;
    logic             pin_stable;
    logic [2:0][3:0]  port_sync;
    logic [3:0]       port_last;
    logic             hi_active;
    logic             lo_active;
    tlpiu_fsm_t       fsm;
    logic [15:0]      vec_addr;
    logic             push;
    logic             load;
    logic [7:0]       rdata;
  } tlpiu_state_t;

endpackage : tlpiu_pkg

// *** core/tlpiu_core.sv ***
// two-level priority interrupt unit with register port and core handshake
`timescale 1ns/1ps

module tlpiu_core (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire tlpiu_pkg::tlpiu_bus_t reg_bus,
  output logic [7:0]             reg_rdata,
  input  wire logic              timer_zero_overflow,
  input  wire logic              external_pin_zero,
  input  wire logic [3:0]        port_b_pins,
  input  wire logic              periph_request,
  input  wire logic              periph_request_high,
  input  wire logic              return_from_interrupt_instruction,
  output logic                   push_return_address,
  output logic                   load_program_counter,
  output logic [15:0]            vector_address,
  output logic                   high_in_service,
  output logic                   low_in_service
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  tlpiu_pkg::tlpiu_state_t st;
  tlpiu_pkg::tlpiu_state_t next_st;

  logic       pin_rise;
  logic [3:0] port_mismatch;
  logic       req_timer;
  logic       req_pin0;
  logic       req_port;
  logic       hi_req;
  logic       lo_req;
  logic       any_req;

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  // a pin edge counts once the second and third stages agree
  assign pin_rise = (st.pin_sync[1] == st.pin_sync[2]) && st.pin_sync[2] &&
                    !st.pin_stable;
  // settled pins that differ from the value last read
  assign port_mismatch = ~(st.port_sync[1] ^ st.port_sync[2]) &
                         (st.port_sync[2] ^ st.port_last);

  // each source: flag and its own enable
  assign req_timer = st.ctrl[tlpiu_pkg::BIT_FLAG_TIMER] &
                     st.ctrl[tlpiu_pkg::BIT_EN_TIMER];
  assign req_pin0  = st.ctrl[tlpiu_pkg::BIT_FLAG_PIN0] &
                     st.ctrl[tlpiu_pkg::BIT_EN_PIN0];
  assign req_port  = st.ctrl[tlpiu_pkg::BIT_FLAG_PORT] &
                     st.ctrl[tlpiu_pkg::BIT_EN_PORT];

  // compatibility mode: one level, peripheral group gated by bit 6
  assign any_req = st.ctrl[tlpiu_pkg::BIT_GLOBAL_HIGH] &
                   (req_timer | req_pin0 | req_port |
                    (st.ctrl[tlpiu_pkg::BIT_GLOBAL_LOW] &
                     periph_request));

  // priority mode: bit 7 admits high, bit 6 low, bit 7 low blocks all
  assign hi_req = st.ctrl[tlpiu_pkg::BIT_GLOBAL_HIGH] &
                  ((req_timer & st.prio[1]) | req_pin0 |
                   (req_port & st.prio[0]) |
                   (periph_request & periph_request_high));
  assign lo_req = st.ctrl[tlpiu_pkg::BIT_GLOBAL_HIGH] &
                  st.ctrl[tlpiu_pkg::BIT_GLOBAL_LOW] & !st.hi_active &
                  ((req_timer & !st.prio[1]) |
                   (req_port & !st.prio[0]) |
                   (periph_request & !periph_request_high));

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st       = st;
    next_st.push  = 1'b0;
    next_st.load  = 1'b0;
    next_st.rdata = 8'h00;

    // three-stage synchronisers for pins
    next_st.pin_sync  = {st.pin_sync[1:0], external_pin_zero};
    next_st.port_sync = {st.port_sync[1:0], port_b_pins};
    if (st.pin_sync[1] == st.pin_sync[2]) begin
      next_st.pin_stable = st.pin_sync[2];
    end

    // register writes
    if (reg_bus.wr) begin
      case (reg_bus.addr)
        tlpiu_pkg::ADDR_MAIN_CONTROL: next_st.ctrl = reg_bus.wdata;
        tlpiu_pkg::ADDR_RESET_CONTROL: begin
          next_st.prio_mode = reg_bus.wdata[tlpiu_pkg::BIT_PRIO_MODE];
        end
        tlpiu_pkg::ADDR_PRIORITY: begin
          next_st.prio = {reg_bus.wdata[tlpiu_pkg::BIT_PRI_TIMER],
                          reg_bus.wdata[tlpiu_pkg::BIT_PRI_PORT]};
        end
        default: ;
      endcase
    end

    // register reads, data one cycle later
    if (reg_bus.rd) begin
      case (reg_bus.addr)
        tlpiu_pkg::ADDR_MAIN_CONTROL: next_st.rdata = st.ctrl;
        tlpiu_pkg::ADDR_RESET_CONTROL: begin
          next_st.rdata = {st.prio_mode, 7'h00};
        end
        tlpiu_pkg::ADDR_PRIORITY: begin
          next_st.rdata = {5'h00, st.prio[1], 1'b0, st.prio[0]};
        end
        tlpiu_pkg::ADDR_PORT_B: begin
          next_st.rdata     = {st.port_sync[2], 4'h0};
          next_st.port_last = st.port_sync[2];
        end
        default: next_st.rdata = 8'h00;
      endcase
    end

    // hardware sets flags regardless of enables; set beats a write
    if (timer_zero_overflow) begin
      next_st.ctrl[tlpiu_pkg::BIT_FLAG_TIMER] = 1'b1;
    end
    if (pin_rise) begin
      next_st.ctrl[tlpiu_pkg::BIT_FLAG_PIN0] = 1'b1;
    end
    if (|port_mismatch) begin
      next_st.ctrl[tlpiu_pkg::BIT_FLAG_PORT] = 1'b1;
    end

    // return re-arms the enable cleared on entry
    if (return_from_interrupt_instruction) begin
      if (!st.prio_mode || st.hi_active) begin
        next_st.ctrl[tlpiu_pkg::BIT_GLOBAL_HIGH] = 1'b1;
        next_st.hi_active = 1'b0;
      end else if (st.lo_active) begin
        next_st.ctrl[tlpiu_pkg::BIT_GLOBAL_LOW] = 1'b1;
        next_st.lo_active = 1'b0;
      end
    end

    // acceptance sequencer, one decision per cycle
    case (st.fsm)
      tlpiu_pkg::TLPIU_IDLE: begin
        if (!st.prio_mode && any_req) begin
          next_st.ctrl[tlpiu_pkg::BIT_GLOBAL_HIGH] = 1'b0;
          next_st.hi_active = 1'b1;
          next_st.vec_addr  = tlpiu_pkg::VEC_HIGH;
          next_st.push      = 1'b1;
          next_st.fsm       = tlpiu_pkg::TLPIU_PUSH;
        end else if (st.prio_mode && hi_req) begin
          next_st.ctrl[tlpiu_pkg::BIT_GLOBAL_HIGH] = 1'b0;
          next_st.hi_active = 1'b1;
          next_st.vec_addr  = tlpiu_pkg::VEC_HIGH;
          next_st.push      = 1'b1;
          next_st.fsm       = tlpiu_pkg::TLPIU_PUSH;
        end else if (st.prio_mode && lo_req) begin
          next_st.ctrl[tlpiu_pkg::BIT_GLOBAL_LOW] = 1'b0;
          next_st.lo_active = 1'b1;
          next_st.vec_addr  = tlpiu_pkg::VEC_LOW;
          next_st.push      = 1'b1;
          next_st.fsm       = tlpiu_pkg::TLPIU_PUSH;
        end
      end
      tlpiu_pkg::TLPIU_PUSH: begin
        next_st.load = 1'b1;
        next_st.fsm  = tlpiu_pkg::TLPIU_LOAD;
      end
      tlpiu_pkg::TLPIU_LOAD: next_st.fsm = tlpiu_pkg::TLPIU_IDLE;
      default: next_st.fsm = tlpiu_pkg::TLPIU_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st           <= '0;
      st.ctrl      <= tlpiu_pkg::RST_MAIN_CONTROL;
      st.prio_mode <= tlpiu_pkg::RST_PRIO_MODE;
      st.prio      <= tlpiu_pkg::RST_PRIORITY;
      st.fsm       <= tlpiu_pkg::TLPIU_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign reg_rdata            = st.rdata;
  assign push_return_address  = st.push;
  assign load_program_counter = st.load;
  assign vector_address       = st.vec_addr;
  assign high_in_service      = st.hi_active;
  assign low_in_service       = st.lo_active;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_push;
    st.push && st.fsm == tlpiu_pkg::TLPIU_PUSH;
  endsequence
  sequence s_load;
    st.load && st.fsm == tlpiu_pkg::TLPIU_LOAD;
  endsequence

  a_push_then_load: assert property (s_push |-> ##1 s_load ##1 !st.push)
    else $error("vector load did not follow push");
  a_high_vector_addr: assert property (
    $rose(st.hi_active) && st.prio_mode |-> st.vec_addr == tlpiu_pkg::VEC_HIGH)
    else $error("high entry with wrong vector");
  a_low_vector_addr: assert property (
    $rose(st.lo_active) |-> st.vec_addr == tlpiu_pkg::VEC_LOW &&
                            !st.ctrl[tlpiu_pkg::BIT_GLOBAL_LOW])
    else $error("low entry with wrong vector or enable");
  a_compat_vector: assert property (
    st.push && !st.prio_mode |-> st.vec_addr == tlpiu_pkg::VEC_HIGH)
    else $error("compatibility entry not at high vector");
  a_entry_clears_high: assert property (
    $rose(st.hi_active) |-> !st.ctrl[tlpiu_pkg::BIT_GLOBAL_HIGH] && st.push)
    else $error("global enable still set after entry");
  a_no_low_in_high: assert property (
    st.hi_active && st.prio_mode |=> !$rose(st.lo_active))
    else $error("low request accepted during high service");
  a_blocked_no_push: assert property (
    !st.ctrl[tlpiu_pkg::BIT_GLOBAL_HIGH] && st.fsm == tlpiu_pkg::TLPIU_IDLE
    |=> !st.push)
    else $error("accepted with global enable clear");
  a_return_rearms: assert property (
    return_from_interrupt_instruction && st.hi_active && !reg_bus.wr &&
    st.fsm == tlpiu_pkg::TLPIU_IDLE |=>
    st.ctrl[tlpiu_pkg::BIT_GLOBAL_HIGH] && !st.hi_active)
    else $error("return did not re-arm global enable");
  a_timer_flag_set: assert property (
    timer_zero_overflow |=> st.ctrl[tlpiu_pkg::BIT_FLAG_TIMER])
    else $error("timer flag lost");
  a_port_flag_set: assert property (
    |port_mismatch |=> st.ctrl[tlpiu_pkg::BIT_FLAG_PORT])
    else $error("port change flag not set on mismatch");

  // ----------------------------------------------------------------
  // flag checks
  // ----------------------------------------------------------------
  // a software write to the main register is the only way to drop the
  // timer flag; without one the flag must survive every cycle
  a_timer_flag_holds: assert property (
    st.ctrl[tlpiu_pkg::BIT_FLAG_TIMER] &&
    !(reg_bus.wr && reg_bus.addr == tlpiu_pkg::ADDR_MAIN_CONTROL)
    |=> st.ctrl[tlpiu_pkg::BIT_FLAG_TIMER])
    else $error("timer flag dropped without a write");

  // a settled pin edge marks the flag whatever the enables hold
  a_pin_flag_set: assert property (
    pin_rise |=> st.ctrl[tlpiu_pkg::BIT_FLAG_PIN0])
    else $error("pin flag not set on edge");

  // a port read copies the settled pins, which ends the mismatch
  a_port_read_ends: assert property (
    reg_bus.rd && reg_bus.addr == tlpiu_pkg::ADDR_PORT_B
    |=> st.port_last == $past(st.port_sync[2]))
    else $error("port read did not latch the pins");

  // ----------------------------------------------------------------
  // register port checks
  // ----------------------------------------------------------------
  // read data stand one cycle after the strobe and are zero otherwise
  a_read_main_data: assert property (
    reg_bus.rd && reg_bus.addr == tlpiu_pkg::ADDR_MAIN_CONTROL
    |=> st.rdata == $past(st.ctrl))
    else $error("main register read returned wrong data");
  a_read_idle_zero: assert property (
    !reg_bus.rd |=> st.rdata == 8'h00)
    else $error("read data not zero outside a read");

  // the mode bit follows a write of the reset control register
  a_mode_write: assert property (
    reg_bus.wr && reg_bus.addr == tlpiu_pkg::ADDR_RESET_CONTROL
    |=> st.prio_mode == $past(reg_bus.wdata[tlpiu_pkg::BIT_PRIO_MODE]))
    else $error("priority mode bit did not take the write");

  // ----------------------------------------------------------------
  // acceptance checks
  // ----------------------------------------------------------------
  // a low entry needs both the high and the low global enables set
  a_low_needs_both: assert property (
    $rose(st.lo_active) |->
    $past(st.ctrl[tlpiu_pkg::BIT_GLOBAL_HIGH]) &&
    $past(st.ctrl[tlpiu_pkg::BIT_GLOBAL_LOW]))
    else $error("low entry without both global enables");

  // a push is only launched from idle, so one vector per decision
  a_single_accept: assert property (
    st.fsm != tlpiu_pkg::TLPIU_IDLE |=> !st.push)
    else $error("second push inside an acceptance");

  // the vector only moves when a new entry is pushed
  a_vector_stands: assert property (
    $changed(st.vec_addr) |-> st.push)
    else $error("vector changed outside an entry");

  // compatibility mode: a peripheral request waits for bit 6
  a_compat_periph_gate: assert property (
    !st.prio_mode && !st.ctrl[tlpiu_pkg::BIT_GLOBAL_LOW] && periph_request &&
    !req_timer && !req_pin0 && !req_port |=> !st.push)
    else $error("peripheral accepted with group enable clear");

  // an armed pin edge with nothing else pending: flag on the next
  // edge, push on the one after, four to five cycles from the pin
  sequence s_pin_armed;
    pin_rise && st.ctrl[tlpiu_pkg::BIT_GLOBAL_HIGH] &&
    st.ctrl[tlpiu_pkg::BIT_EN_PIN0] && st.fsm == tlpiu_pkg::TLPIU_IDLE;
  endsequence
  sequence s_nothing_pending;
    !any_req && !hi_req && !lo_req && !reg_bus.wr;
  endsequence
  a_pin_latency: assert property (
    s_pin_armed and s_nothing_pending |=> ##1 s_push)
    else $error("pin edge not vectored in time");

  // a high request must win while a low routine is running
  a_high_preempts: assert property (
    st.prio_mode && st.lo_active && hi_req &&
    st.fsm == tlpiu_pkg::TLPIU_IDLE |=> st.push && st.hi_active)
    else $error("high request did not preempt low service");

endmodule : tlpiu_core

// *** sim/tlpiu_core_model.sv ***
// core-side model: return stack pushes, program counter, return pulses
`timescale 1ns/1ps
module tlpiu_core_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        push_return_address,
  input  wire logic        load_program_counter,
  input  wire logic [15:0] vector_address,
  input  wire logic        ret_cmd,
  output logic             return_from_interrupt_instruction,
  output logic [15:0]      program_counter,
  output logic [7:0]       push_count,
  output logic             order_error
);
  logic pushed_last;
  // push first, then take the vector; return pulse lags the command
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      return_from_interrupt_instruction <= 1'b0;
      program_counter                   <= 16'h0000;
      push_count                        <= 8'h00;
      order_error                       <= 1'b0;
      pushed_last                       <= 1'b0;
    end else begin
      return_from_interrupt_instruction <= ret_cmd;
      pushed_last <= push_return_address;
      if (push_return_address) begin
        push_count <= push_count + 8'h01;
      end
      if (load_program_counter) begin
        program_counter <= vector_address;
        if (!pushed_last) begin
          order_error <= 1'b1;
        end
      end
    end
  end
endmodule : tlpiu_core_model

// *** sim/tb_two_level_priority_interrupt_unit.sv ***
// testbench of the two-level priority interrupt unit
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_two_level_priority_interrupt_unit;
  logic                  sys_clk, rst, timer_zero_overflow, ret_cmd;
  logic                  external_pin_zero, periph_request;
  logic                  periph_request_high, return_from_interrupt_instruction;
  logic                  push_return_address, load_program_counter;
  logic                  high_in_service, low_in_service, order_error;
  logic [3:0]            port_b_pins;
  logic [7:0]            reg_rdata, push_count;
  logic [15:0]           vector_address, program_counter;
  tlpiu_pkg::tlpiu_bus_t reg_bus;
  int                    checks, miscompares, cycles;

  tlpiu_core dut (
    .sys_clk(sys_clk), .rst(rst), .reg_bus(reg_bus), .reg_rdata(reg_rdata),
    .timer_zero_overflow(timer_zero_overflow),
    .external_pin_zero(external_pin_zero), .port_b_pins(port_b_pins),
    .periph_request(periph_request),
    .periph_request_high(periph_request_high),
    .return_from_interrupt_instruction(return_from_interrupt_instruction),
    .push_return_address(push_return_address),
    .load_program_counter(load_program_counter),
    .vector_address(vector_address), .high_in_service(high_in_service),
    .low_in_service(low_in_service)
  );
  tlpiu_core_model core (
    .sys_clk(sys_clk), .rst(rst), .push_return_address(push_return_address),
    .load_program_counter(load_program_counter),
    .vector_address(vector_address), .ret_cmd(ret_cmd),
    .return_from_interrupt_instruction(return_from_interrupt_instruction),
    .program_counter(program_counter), .push_count(push_count),
    .order_error(order_error)
  );

  // clock and hang guard
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      print_verdict();
    end
  end

  task print_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // register port accesses
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_bus <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    reg_bus <= '0;
  endtask : wr
  task rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk);
    reg_bus <= '0;
    #1 `CHK(reg_rdata, e)
  endtask : rd
  // acceptance: one push, then the vector reaches the core
  task wait_push(input logic [15:0] v);
    logic [7:0] c0;
    int n;
    c0 = push_count;
    n = 0;
    while (push_count === c0 && n < 30) begin
      @(posedge sys_clk);
      #1 n++;
    end
    `CHK(push_count, c0 + 8'h01)
    @(posedge sys_clk);
    #1 `CHK(program_counter, v)
    `CHK(order_error, 1'b0)
  endtask : wait_push
  task no_push;
    logic [7:0] c0;
    c0 = push_count;
    repeat (10) @(posedge sys_clk);
    #1 `CHK(push_count, c0)
  endtask : no_push
  task pulse_timer;
    @(posedge sys_clk);
    timer_zero_overflow <= 1'b1;
    @(posedge sys_clk);
    timer_zero_overflow <= 1'b0;
  endtask : pulse_timer
  task ret;
    @(posedge sys_clk);
    ret_cmd <= 1'b1;
    @(posedge sys_clk);
    ret_cmd <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask : ret
  task req(input logic on, input logic hi);
    @(posedge sys_clk);
    periph_request      <= on;
    periph_request_high <= hi;
  endtask : req

  // main sequence
  initial begin
    int n;
    sys_clk = 1'b0; rst = 1'b1; reg_bus = '0; ret_cmd = 1'b0;
    timer_zero_overflow = 1'b0; external_pin_zero = 1'b0; port_b_pins = 4'h0;
    periph_request = 1'b0; periph_request_high = 1'b0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h00);
    rd(2'h2, 8'h05);
    wr(2'h0, 8'h38);
    rd(2'h0, 8'h38);
    wr(2'h0, 8'h00);
    pulse_timer();
    rd(2'h0, 8'h04);
    rd(2'h0, 8'h04);
    wr(2'h0, 8'h00);
    rd(2'h0, 8'h00);
    @(posedge sys_clk);
    port_b_pins <= 4'h5;
    repeat (6) @(posedge sys_clk);
    rd(2'h0, 8'h01);
    wr(2'h0, 8'h00);
    rd(2'h0, 8'h01);
    rd(2'h3, 8'h50);
    wr(2'h0, 8'h00);
    rd(2'h0, 8'h00);
    $display("test registers and flags done");
    wr(2'h0, 8'ha0);
    pulse_timer();
    wait_push(16'h0008);
    `CHK(high_in_service, 1'b1)
    rd(2'h0, 8'h24);
    wr(2'h0, 8'h20);
    ret();
    rd(2'h0, 8'ha0);
    wr(2'h0, 8'h80);
    req(1'b1, 1'b0);
    no_push();
    wr(2'h0, 8'hc0);
    wait_push(16'h0008);
    req(1'b0, 1'b0);
    rd(2'h0, 8'h40);
    ret();
    rd(2'h0, 8'hc0);
    wr(2'h0, 8'h90);
    @(posedge sys_clk);
    external_pin_zero <= 1'b1;
    @(posedge sys_clk);
    n = 0;
    do begin
      @(posedge sys_clk);
      #1 n++;
    end while (push_return_address !== 1'b1 && n < 10);
    `CHK(n >= 3 && n <= 4, 1'b1)
    rd(2'h0, 8'h12);
    wr(2'h0, 8'h10);
    ret();
    rd(2'h0, 8'h90);
    $display("test compatibility mode done");
    wr(2'h1, 8'h80);
    rd(2'h1, 8'h80);
    wr(2'h2, 8'h01);
    rd(2'h2, 8'h01);
    wr(2'h0, 8'he0);
    pulse_timer();
    wait_push(16'h0018);
    `CHK(low_in_service, 1'b1)
    rd(2'h0, 8'ha4);
    wr(2'h0, 8'ha0);
    req(1'b1, 1'b1);
    wait_push(16'h0008);
    req(1'b0, 1'b0);
    rd(2'h0, 8'h20);
    wr(2'h0, 8'he0);
    req(1'b1, 1'b0);
    no_push();
    req(1'b0, 1'b0);
    ret();
    `CHK(high_in_service, 1'b0)
    wr(2'h0, 8'ha0);
    ret();
    rd(2'h0, 8'he0);
    wr(2'h0, 8'h60);
    req(1'b1, 1'b0);
    no_push();
    wr(2'h0, 8'ha0);
    no_push();
    wr(2'h0, 8'he0);
    wait_push(16'h0018);
    $display("test priority mode done");
    print_verdict();
  end
endmodule : tb_two_level_priority_interrupt_unit
